// ===== rtl/pmc_power_mode_controller.v
// power mode controller: clock source select and run/idle/sleep gating
//
// Decided for this implementation: the register offsets and the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none
`include "pmc_defs.vh"
module pmc_power_mode_controller (
    input wire clk_i,
    input wire reset_n_i,
    input wire [1:0] addr_i,
    input wire [7:0] wdata_i,
    input wire wr_i,
    input wire rd_i,
    output reg [7:0] rdata_o,
    input wire halt_i,
    input wire irq_i,
    input wire wdt_timeout_i,
    input wire wdt_enabled_i,
    input wire two_speed_en_i,
    input wire fail_safe_en_i,
    input wire pri_ready_i,
    input wire sec_ready_i,
    input wire int_ready_i,
    output reg pri_osc_en_o,
    output reg sec_osc_en_o,
    output reg int_osc_en_o,
    output reg lf_osc_en_o,
    output reg [1:0] sys_src_o,
    output reg [2:0] int_freq_o,
    output reg cpu_clk_en_o,
    output reg periph_clk_en_o,
    output reg cpu_run_o,
    output reg wdt_reset_o
);
    localparam [3:0] ST_RUN = 4'h1;
    localparam [3:0] ST_IDLE = 4'h2;
    localparam [3:0] ST_SLEEP = 4'h4;
    localparam [3:0] ST_WAKE = 4'h8;

    // oscillator ready lines come from other clocks
    reg [2:0] rdy_meta;
    reg [2:0] rdy_sync;
    reg [1:0] ev_meta;
    reg [1:0] ev_sync;
    reg [2:0] strap_meta;
    reg [2:0] strap_sync;
    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rdy_meta <= 3'h0;
            rdy_sync <= 3'h0;
            ev_meta <= 2'h0;
            ev_sync <= 2'h0;
            strap_meta <= 3'h0;
            strap_sync <= 3'h0;
        end else begin
            rdy_meta <= {int_ready_i, sec_ready_i, pri_ready_i};
            rdy_sync <= rdy_meta;
            ev_meta <= {wdt_timeout_i, irq_i};
            ev_sync <= ev_meta;
            strap_meta <= {fail_safe_en_i, two_speed_en_i, wdt_enabled_i};
            strap_sync <= strap_meta;
        end
    end
    wire wdt_en_s = strap_sync[0];
    wire two_speed_s = strap_sync[1];
    wire fail_safe_s = strap_sync[2];
    // internal block may stand in for a source that is not ready yet
    wire fill_src_en = two_speed_s | fail_safe_s;
    wire pri_rdy = rdy_sync[0];
    wire sec_rdy = rdy_sync[1];
    wire int_rdy = rdy_sync[2];
    wire irq_s = ev_sync[0];
    wire wdt_s = ev_sync[1];
    wire fill_ok = fill_src_en & int_rdy;

    reg idle_on_halt;
    reg [2:0] internal_freq_select;
    reg secondary_osc_enable;
    reg [1:0] clock_source_select;
    reg primary_running_flag;
    reg secondary_active_flag;
    reg [3:0] state;
    reg [1:0] active_src;
    reg from_sleep;
    reg wdt_prev;
    reg [7:0] delay_cnt;
    reg on_fill;
    wire wdt_rise = wdt_s & ~wdt_prev;

    // requested source from the select field
    reg [1:0] req_src;
    always @* begin
        if (clock_source_select[1])
            req_src = `PMC_SRC_INT;
        else if (clock_source_select[0])
            req_src = `PMC_SRC_SEC;
        else
            req_src = `PMC_SRC_PRI;
    end

    reg req_ok;
    reg act_rdy;
    always @* begin
        case (req_src)
            `PMC_SRC_SEC: req_ok = secondary_osc_enable & sec_rdy;
            `PMC_SRC_INT: req_ok = int_rdy;
            default: req_ok = pri_rdy;
        endcase
        case (active_src)
            `PMC_SRC_SEC: act_rdy = sec_rdy;
            `PMC_SRC_INT: act_rdy = int_rdy;
            default: act_rdy = pri_rdy;
        endcase
    end

    // register file
    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            idle_on_halt <= 1'b0;
            internal_freq_select <= 3'h0;
            secondary_osc_enable <= 1'b0;
            clock_source_select <= 2'h0;
        end else if (wr_i && addr_i == `PMC_ADDR_CTRL) begin
            idle_on_halt <= wdata_i[`PMC_CTRL_IDLE_BIT];
            internal_freq_select <= wdata_i[`PMC_CTRL_INTERNAL_FREQ_SELECT_HI:`PMC_CTRL_INTERNAL_FREQ_SELECT_LO];
            secondary_osc_enable <= wdata_i[`PMC_CTRL_SOSCEN_BIT];
            clock_source_select <= wdata_i[`PMC_CTRL_SCS_HI:`PMC_CTRL_SCS_LO];
        end
    end

    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rdata_o <= 8'h00;
        end else if (rd_i) begin
            case (addr_i)
                `PMC_ADDR_CTRL: rdata_o <= {idle_on_halt, internal_freq_select, 1'b0,
                    secondary_osc_enable, clock_source_select};
                `PMC_ADDR_STAT: rdata_o <= {2'h0, state[1] | state[2], cpu_run_o,
                    active_src, secondary_active_flag, primary_running_flag};
                default: rdata_o <= 8'h00;
            endcase
        end else begin
            rdata_o <= 8'h00;
        end
    end

    // mode sequencer
    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state <= ST_WAKE;
            active_src <= `PMC_SRC_PRI;
            from_sleep <= 1'b1;
            on_fill <= 1'b0;
            primary_running_flag <= 1'b0;
            secondary_active_flag <= 1'b0;
            delay_cnt <= 8'h00;
            wdt_prev <= 1'b0;
            wdt_reset_o <= 1'b0;
        end else begin
            wdt_prev <= wdt_s;
            wdt_reset_o <= 1'b0;
            // fill-in ends once the chosen source is ready
            if (on_fill && act_rdy) begin
                on_fill <= 1'b0;
                primary_running_flag <= (active_src == `PMC_SRC_PRI);
                secondary_active_flag <= (active_src == `PMC_SRC_SEC);
            end
            case (state)
                ST_RUN: begin
                    if (wdt_rise) begin
                        wdt_reset_o <= 1'b1;
                    end else if (halt_i) begin
                        if (idle_on_halt) begin
                            state <= ST_IDLE;
                        end else begin
                            state <= ST_SLEEP;
                            on_fill <= 1'b0;
                            primary_running_flag <= 1'b0;
                            secondary_active_flag <= 1'b0;
                        end
                    end else if (req_src != active_src && req_ok) begin
                        active_src <= req_src;
                        on_fill <= 1'b0;
                        primary_running_flag <= (req_src == `PMC_SRC_PRI);
                        secondary_active_flag <= (req_src == `PMC_SRC_SEC);
                    end
                end
                ST_IDLE: begin
                    if (irq_s || wdt_rise) begin
                        state <= ST_WAKE;
                        from_sleep <= 1'b0;
                        delay_cnt <= 8'h00;
                    end
                end
                ST_SLEEP: begin
                    if (irq_s || wdt_rise) begin
                        state <= ST_WAKE;
                        from_sleep <= 1'b1;
                        delay_cnt <= 8'h00;
                        active_src <= req_src;
                    end
                end
                ST_WAKE: begin
                    if (from_sleep && !act_rdy && !fill_ok) begin
                        delay_cnt <= 8'h00;
                    end else if (delay_cnt == `PMC_READY_DELAY - 8'h01) begin
                        state <= ST_RUN;
                        on_fill <= from_sleep && !act_rdy;
                        if (from_sleep && act_rdy) begin
                            primary_running_flag <= (active_src == `PMC_SRC_PRI);
                            secondary_active_flag <= (active_src == `PMC_SRC_SEC);
                        end
                    end else begin
                        delay_cnt <= delay_cnt + 8'h01;
                    end
                end
                default: state <= ST_RUN;
            endcase
        end
    end

    // internal block fills in while waiting for the source after sleep or reset
    wire fill_in = fill_ok && !act_rdy &&
        (((state == ST_WAKE) && from_sleep) || on_fill);
    wire sleeping = (state == ST_SLEEP);
    wire waking_dark = (state == ST_WAKE) && from_sleep && !act_rdy && !fill_in;

    // clock gating and oscillator enables
    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pri_osc_en_o <= 1'b0;
            sec_osc_en_o <= 1'b0;
            int_osc_en_o <= 1'b0;
            lf_osc_en_o <= 1'b0;
            sys_src_o <= `PMC_SRC_PRI;
            int_freq_o <= 3'h0;
            cpu_clk_en_o <= 1'b0;
            periph_clk_en_o <= 1'b0;
            cpu_run_o <= 1'b0;
        end else begin
            // a requested primary or internal source is started so that the switch can complete; the secondary follows SOSCEN only
            pri_osc_en_o <= !sleeping &&
                (active_src == `PMC_SRC_PRI || req_src == `PMC_SRC_PRI);
            sec_osc_en_o <= secondary_osc_enable;
            int_osc_en_o <= (!sleeping &&
                (active_src == `PMC_SRC_INT || req_src == `PMC_SRC_INT)) ||
                (fill_src_en && ((state == ST_WAKE) || on_fill));
            lf_osc_en_o <= wdt_en_s || fail_safe_s ||
                (!sleeping && active_src == `PMC_SRC_INT);
            sys_src_o <= fill_in ? `PMC_SRC_INT : active_src;
            int_freq_o <= internal_freq_select;
            cpu_clk_en_o <= (state == ST_RUN) || ((state == ST_WAKE) && !waking_dark);
            periph_clk_en_o <= !sleeping && !waking_dark;
            cpu_run_o <= (state == ST_RUN) && !(halt_i);
        end
    end
endmodule
`default_nettype wire

// ===== rtl/pmc_defs.vh
// constants for the power mode controller
`ifndef PMC_DEFS_VH
`define PMC_DEFS_VH
`define PMC_ADDR_CTRL 2'h0
`define PMC_ADDR_STAT 2'h1
`define PMC_CTRL_IDLE_BIT 7
`define PMC_CTRL_INTERNAL_FREQ_SELECT_HI 6
`define PMC_CTRL_INTERNAL_FREQ_SELECT_LO 4
`define PMC_CTRL_SOSCEN_BIT 2
`define PMC_CTRL_SCS_HI 1
`define PMC_CTRL_SCS_LO 0
`define PMC_CTRL_RESET 8'h00
`define PMC_SRC_PRI 2'h0
`define PMC_SRC_SEC 2'h1
`define PMC_SRC_INT 2'h2
`define PMC_READY_DELAY 8'h08
`endif

// ===== tb/pmc_checker_sva.sv
// assertion checker for the power mode controller ports
`timescale 1ns/100ps
`default_nettype none
module pmc_checker (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic [1:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [7:0] rdata_o,
    input wire logic halt_i,
    input wire logic pri_osc_en_o,
    input wire logic [1:0] sys_src_o,
    input wire logic [2:0] int_freq_o,
    input wire logic cpu_clk_en_o,
    input wire logic periph_clk_en_o,
    input wire logic cpu_run_o,
    input wire logic wdt_reset_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    logic [7:0] ctl;
    logic [3:0] low;
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ctl <= 8'h00;
            low <= 4'h0;
        end else begin
            if (wr_i && addr_i == 2'h0) ctl <= wdata_i;
            low <= cpu_run_o ? 4'h0 : low + {3'h0, low != 4'hf};
        end
    end
    a_sleep_entry: assert property (halt_i && cpu_run_o && !ctl[7] |->
        ##[1:3] !cpu_clk_en_o && !periph_clk_en_o) else $error("sleep left a clock on");
    a_idle_entry: assert property (halt_i && cpu_run_o && ctl[7] |->
        ##[1:3] !cpu_clk_en_o && periph_clk_en_o) else $error("idle gating wrong");
    a_run_clocked: assert property (cpu_run_o |-> cpu_clk_en_o && periph_clk_en_o)
        else $error("running without clocks");
    a_src_legal: assert property (sys_src_o != 2'h3) else $error("illegal source");
    a_sec_pri_off: assert property (sys_src_o == 2'h1 && $past(sys_src_o) == 2'h1 &&
        ctl[1:0] == 2'h1 |=> !pri_osc_en_o) else $error("primary kept on in secondary run");
    a_freq_follow: assert property (wr_i && addr_i == 2'h0 |->
        ##2 int_freq_o == ctl[6:4]) else $error("internal speed not updated");
    a_read_quiet: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
        else $error("read data outside read cycle");
    a_ready_delay: assert property ($rose(cpu_run_o) |-> low >= 4'h8)
        else $error("cpu ran before ready delay");
    a_wdt_pulse: assert property (wdt_reset_o |=> !wdt_reset_o)
        else $error("watchdog reset pulse too long");
    cover property (halt_i && ctl[7]);
    cover property ($rose(cpu_run_o));
    cover property (wdt_reset_o);
endmodule
bind pmc_power_mode_controller pmc_checker pmc_checker_inst (.clk_i, .reset_n_i, .addr_i,
    .wdata_i, .wr_i, .rd_i, .rdata_o, .halt_i, .pri_osc_en_o, .sys_src_o, .int_freq_o,
    .cpu_clk_en_o, .periph_clk_en_o, .cpu_run_o, .wdt_reset_o);
`default_nettype wire

// ===== tb/pmc_osc_model.sv
// start-up model of the three selectable oscillators
`timescale 1ns/100ps
`default_nettype none
module pmc_osc_model (
    input wire logic clk_i,
    input wire logic [2:0] en_i,
    input wire logic slow_i,
    output logic [2:0] ready_o
);
    int cnt [3];
    initial ready_o = 3'h0;
    always @(posedge clk_i) begin
        for (int k = 0; k < 3; k++) begin
            cnt[k] <= en_i[k] ? cnt[k] + 1 : 0;
            ready_o[k] <= en_i[k] && cnt[k] >= ((slow_i && k == 0) ? 24 : 3);
        end
    end
endmodule
`default_nettype wire

// ===== tb/tb_top.sv
// self-checking bench for the power mode controller
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    logic clk_i = 1'b0, reset_n_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0, halt_i = 1'b0;
    logic irq_i = 1'b0, wdt_timeout_i = 1'b0, two_speed_en_i = 1'b0, slow = 1'b0, fsafe = 1'b0;
    logic [1:0] addr_i = 2'h0, sys_src_o;
    logic [7:0] wdata_i = 8'h00, rdata_o, exp_ctrl = 8'h00;
    logic [2:0] en, rdy, int_freq_o;
    logic lf_osc_en_o, cpu_clk_en_o, periph_clk_en_o, cpu_run_o, wdt_reset_o;
    logic [31:0] seed = 32'h396ae209;
    int n_mismatch = 0, compares = 0;
    always #4 clk_i = ~clk_i;
    pmc_power_mode_controller pmc_power_mode_controller_inst (.clk_i, .reset_n_i, .addr_i,
        .wdata_i, .wr_i, .rd_i, .rdata_o, .halt_i, .irq_i, .wdt_timeout_i, .wdt_enabled_i(1'b1),
        .two_speed_en_i, .fail_safe_en_i(fsafe), .pri_ready_i(rdy[0]), .sec_ready_i(rdy[1]),
        .int_ready_i(rdy[2]), .pri_osc_en_o(en[0]), .sec_osc_en_o(en[1]), .int_osc_en_o(en[2]),
        .lf_osc_en_o, .sys_src_o, .int_freq_o, .cpu_clk_en_o, .periph_clk_en_o, .cpu_run_o,
        .wdt_reset_o);
    pmc_osc_model pmc_osc_model_inst (.clk_i, .en_i(en), .slow_i(slow), .ready_o(rdy));
    function automatic logic [7:0] xorshift();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction
    task automatic end_sim();
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
        if (a == 2'h0) exp_ctrl = d & 8'hf7;
    endtask
    task automatic rd(input logic [1:0] a, input logic [7:0] m, input logic [7:0] e);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 cmp(rdata_o & m, e);
    endtask
    task automatic wt(input int s, input logic [1:0] v);
        int i;
        for (i = 0; i < 300 && (s == 1 ? sys_src_o : {1'b0, s ? wdt_reset_o : cpu_run_o}) !== v;
            i++) @(posedge clk_i);
        if (i == 300) begin
            n_mismatch++;
            end_sim();
        end
    endtask
    task automatic hlt();
        @(posedge clk_i);
        halt_i <= 1'b1;
        @(posedge clk_i);
        halt_i <= 1'b0;
        wt(0, 2'h0);
        repeat (3) @(posedge clk_i);
    endtask
    initial begin
        repeat (6) @(posedge clk_i);
        reset_n_i <= 1'b1;
        wt(0, 2'h1);
        rd(2'h1, 8'h3f, 8'h11);
        for (int k = 0; k < 8; k++) begin
            wr(2'h0, xorshift() & 8'hf0);
            rd(2'h0, 8'hf7, exp_ctrl);
            cmp({5'h0, int_freq_o}, {5'h0, exp_ctrl[6:4]});
            rd(2'h2 + 2'(k % 2), 8'hff, 8'h00);
        end
        wr(2'h0, 8'h02);
        wt(1, 2'h2);
        repeat (2) @(posedge clk_i);
        cmp({7'h0, en[0]}, 8'h00);
        rd(2'h1, 8'h3f, 8'h18);
        wr(2'h0, 8'h01);
        repeat (30) @(posedge clk_i);
        cmp({6'h0, sys_src_o}, 8'h02);
        wr(2'h0, 8'h05);
        wt(1, 2'h1);
        repeat (2) @(posedge clk_i);
        rd(2'h1, 8'h3f, 8'h16);
        wr(2'h0, 8'h85);
        hlt();
        cmp({6'h0, cpu_clk_en_o, periph_clk_en_o}, 8'h01);
        cmp({5'h0, en}, 8'h02);
        rd(2'h1, 8'h3f, 8'h26);
        irq_i <= 1'b1;
        wt(0, 2'h1);
        irq_i <= 1'b0;
        rd(2'h1, 8'h3f, 8'h16);
        rd(2'h0, 8'hf7, exp_ctrl);
        wr(2'h0, 8'h00);
        wt(1, 2'h0);
        slow <= 1'b1;
        hlt();
        cmp({4'h0, en[0], lf_osc_en_o, cpu_clk_en_o, periph_clk_en_o}, 8'h04);
        rd(2'h1, 8'h33, 8'h20);
        wdt_timeout_i <= 1'b1;
        wt(0, 2'h1);
        wdt_timeout_i <= 1'b0;
        rd(2'h1, 8'h3f, 8'h11);
        wdt_timeout_i <= 1'b1;
        wt(2, 2'h1);
        wdt_timeout_i <= 1'b0;
        two_speed_en_i <= 1'b1;
        reset_n_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        reset_n_i <= 1'b1;
        wt(0, 2'h1);
        cmp({6'h0, sys_src_o}, 8'h02);
        wt(1, 2'h0);
        two_speed_en_i <= 1'b0;
        fsafe <= 1'b1;
        reset_n_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        reset_n_i <= 1'b1;
        wt(0, 2'h1);
        cmp({6'h0, sys_src_o}, 8'h02);
        wt(1, 2'h0);
        rd(2'h1, 8'h3f, 8'h11);
        end_sim();
    end
endmodule
`default_nettype wire
